// file: shared/rng_csr_consts.svh
/*
 * Offsets, field positions, reset values and counts for the random
 * number generator and clock control register block.
 * Assumes: included by bare name from the design files; definitions only.
 */
`ifndef RNG_CSR_CONSTS_SVH
`define RNG_CSR_CONSTS_SVH

// ----------------------------------------------------------------------
// register addresses on the unit control register bus
// ----------------------------------------------------------------------
`define CLK_CTL_ADDR 40'h8300000000
`define RNG_CTL_ADDR 40'h8300000020
`define RNG_DATA_ADDR 40'h8300000030

// ----------------------------------------------------------------------
// clock generator control word
// ----------------------------------------------------------------------
`define CLK_CTL_WIDTH 37
`define CLK_CTL_RESET 37'h01002011C1
`define CLK_CLAMP_BIT 36
`define CLK_MEM_STRETCH_LSB 34
`define CLK_CHAR_BIT 33
`define CLK_CHANGE_BIT 32
`define CLK_ALIGN_LSB 30
`define CLK_DTM2_BIT 29
`define CLK_DTM1_BIT 28
`define CLK_CORE_STRETCH_LSB 26
`define CLK_PHASE_BIT 25
`define CLK_MEM_DIV_LSB 18
`define CLK_CORE_DIV_LSB 12
`define CLK_FB_DIV_LSB 6
`define CLK_PRE_LSB 0
`define STRETCH_STEP_PS 8'h28

// ----------------------------------------------------------------------
// generator control word
// ----------------------------------------------------------------------
`define RNG_CTL_WIDTH 25
`define RNG_CTL_RESET 25'h0007C0F
`define RNG_SEL_LSB 0
`define RNG_MODE_BIT 3
`define RNG_ANLG_LSB 4
`define RNG_RATE_LSB 6
`define RNG_BYPASS_BIT 8
`define RNG_WAIT_LSB 9

// ----------------------------------------------------------------------
// random register constants and pacing
// ----------------------------------------------------------------------
`define RNG_POLY 64'h231DCEE91262B8A3
`define RNG_ALL_ONES 64'hFFFFFFFFFFFFFFFF
`define DIAG_GAP_CYCLES 17'h00040

`endif

// file: shared/rng_csr_pkg.sv
/*
 * Types shared by the generator register block and its shift register.
 * Assumes: compiled before the design modules.
 */
package rng_csr_pkg;
	// one bit per noise cell, cell 2 in the top bit
	typedef logic [2:0] cell_sel_t;
	// register access sequencer
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_PACE = 3'h2,
		ST_ANSWER = 3'h4
	} bus_state_t;
endpackage : rng_csr_pkg

// file: hdl/random_shift_register.sv
/*
 * 64-bit random register: polynomial feedback or plain shifting, fed by
 * the exclusive-or of the enabled noise cells, flushed to all ones in polynomial mode.
 * Assumes: noise inputs already synchronised to clk_i.
 */
`timescale 1ns/100ps
`include "rng_csr_consts.svh"

module random_shift_register (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// noise feed
	input wire rng_csr_pkg::cell_sel_t cell_enable_i,
	input wire logic [2:0] noise_i,
	// control
	input wire logic lfsr_mode_i,
	input wire logic flush_i,
	// state
	output logic feed_bit_o,
	output logic [63:0] data_o
);
	import rng_csr_pkg::*;

	logic [63:0] data_ff;
	logic [63:0] nxt_data;
	logic feed_bit;
	logic [63:0] shifted;
	logic [63:0] fb_mask;

	// ------------------------------------------------------------------
	// next value
	// ------------------------------------------------------------------
	// deselected cells contribute zero, so an empty select feeds zeros
	assign feed_bit = ^(noise_i & cell_enable_i);
	assign shifted = {data_ff[62:0], feed_bit};
	// galois form keeps the feedback one gate deep at 200 MHz
	assign fb_mask = data_ff[63] ? `RNG_POLY : 64'h0000000000000000;
	// diagnostic mode ignores the flush so captured noise stays visible
	assign nxt_data = (flush_i && lfsr_mode_i) ? `RNG_ALL_ONES :
		(lfsr_mode_i ? (shifted ^ fb_mask) : shifted);

	// register, reset to the flush state
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			data_ff <= `RNG_ALL_ONES;
		end else begin
			data_ff <= nxt_data;
		end
	end

	assign feed_bit_o = feed_bit;
	assign data_o = data_ff;
endmodule : random_shift_register

// file: hdl/rng_with_clock_csr.sv
/*
 * Random number generator with the clock unit register block: noise cell
 * selection, paced random data reads, and the clock generator control word
 * that reaches the generator only on warm reset.
 * Assumes: noise cells are asynchronous; warm_reset_i and the register bus
 * run on clk_i; a requester holds reg_req_i until reg_ack_o.
 */
`timescale 1ns/100ps
`include "rng_csr_consts.svh"

module rng_with_clock_csr (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// unit control register bus
	input wire logic reg_req_i,
	input wire logic reg_write_i,
	input wire logic [39:0] reg_addr_i,
	input wire logic [63:0] reg_wdata_i,
	output logic reg_ack_o,
	output logic [63:0] reg_rdata_o,
	// noise cells
	input wire logic [2:0] noise_cell_i,
	output rng_csr_pkg::cell_sel_t cell_enable_o,
	output logic [5:0] osc_rate_o,
	output logic bias_bypass_o,
	output logic [1:0] analog_mux_sel_o,
	// clock generator
	input wire logic warm_reset_i,
	output logic clamp_filter_o,
	output logic char_in_o,
	output logic freq_change_o,
	output logic [1:0] memory_stretch_delay_o,
	output logic [7:0] memory_stretch_ps_o,
	output logic [1:0] core_stretch_delay_o,
	output logic [7:0] core_stretch_ps_o,
	output logic align_advance_o,
	output logic align_retard_o,
	output logic serial_test_mode_two_o,
	output logic serial_test_mode_one_o,
	output logic serdes_test_mode_o,
	output logic io_at_memory_rate_o,
	output logic stretch_phase_select_o,
	output logic [6:0] memory_vco_divider_o,
	output logic [5:0] core_vco_divider_o,
	output logic [5:0] feedback_divider_o,
	output logic [5:0] pre_scaler_o
);
	import rng_csr_pkg::*;

	// ------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------
	logic [2:0] sync1_ff, sync2_ff, sync3_ff, noise_ff;
	logic [`RNG_CTL_WIDTH-1:0] rng_ctl_ff;
	logic [`CLK_CTL_WIDTH-1:0] clk_ctl_ff, applied_ff;
	logic [1:0] rate_ff [3];
	bus_state_t state_ff, nxt_state;
	logic [16:0] pace_ff, nxt_pace;
	logic [63:0] rdata_ff, rd_mux, rng_data;
	logic data_ans_ff, serdes_ff, feed_bit;
	logic [7:0] mem_ps_ff, core_ps_ff;
	cell_sel_t cell_en, wr_cell_en;
	logic [2:0] sel;
	logic lfsr_mode, hit_clk, hit_ctl, hit_data, data_rd, pace_busy;
	logic open_slot, take, wr_clk, wr_ctl;
	logic [15:0] wait_cnt;

	// select decode shared by the live select and a select being written
	function automatic cell_sel_t enable_of(input logic [2:0] s);
		logic multi;
		multi = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
		enable_of = multi ? 3'h7 : s;
	endfunction : enable_of

	// stretch code n stands for (n + 1) steps of 40 ps
	function automatic logic [7:0] stretch_ps(input logic [1:0] code);
		stretch_ps = 8'(({6'h00, code} + 8'h01) * `STRETCH_STEP_PS);
	endfunction : stretch_ps

	// ------------------------------------------------------------------
	// noise cell synchronisers
	// ------------------------------------------------------------------
	// three stages; a change counts only once stages two and three agree,
	// which filters the odd metastable resolution of a fast oscillator
	for (genvar i = 0; i < 3; i++) begin : g_noise
		always_ff @(posedge clk_i or negedge rst_b_i) begin
			if (!rst_b_i) begin
				sync1_ff[i] <= 1'h0;
				sync2_ff[i] <= 1'h0;
				sync3_ff[i] <= 1'h0;
				noise_ff[i] <= 1'h0;
			end else begin
				sync1_ff[i] <= noise_cell_i[i];
				sync2_ff[i] <= sync1_ff[i];
				sync3_ff[i] <= sync2_ff[i];
				if (sync2_ff[i] == sync3_ff[i]) begin
					noise_ff[i] <= sync3_ff[i];
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// generator control decode
	// ------------------------------------------------------------------
	assign sel = rng_ctl_ff[`RNG_SEL_LSB +: 3];
	assign lfsr_mode = rng_ctl_ff[`RNG_MODE_BIT];
	assign wait_cnt = rng_ctl_ff[`RNG_WAIT_LSB +: 16];
	assign cell_en = enable_of(sel);
	assign wr_cell_en = enable_of(reg_wdata_i[`RNG_SEL_LSB +: 3]);

	random_shift_register u_shift (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.cell_enable_i(cell_en),
		.noise_i(noise_ff),
		.lfsr_mode_i(lfsr_mode),
		.flush_i(data_ans_ff),
		.feed_bit_o(feed_bit),
		.data_o(rng_data)
	);

	// ------------------------------------------------------------------
	// register bus decode
	// ------------------------------------------------------------------
	assign hit_clk = (reg_addr_i == `CLK_CTL_ADDR);
	assign hit_ctl = (reg_addr_i == `RNG_CTL_ADDR);
	assign hit_data = (reg_addr_i == `RNG_DATA_ADDR);
	assign data_rd = hit_data && !reg_write_i;
	assign pace_busy = (pace_ff != 17'h00000);
	assign open_slot = (state_ff == ST_IDLE) || (state_ff == ST_PACE);
	// a data read waits out the pacing gap; other accesses never wait
	assign take = reg_req_i && open_slot && !(data_rd && pace_busy);
	assign wr_clk = take && reg_write_i && hit_clk;
	assign wr_ctl = take && reg_write_i && hit_ctl;
	// unmapped addresses read zero and ignore writes; data is read-only
	assign rd_mux = hit_clk ? {27'h0000000, clk_ctl_ff} :
		hit_ctl ? {39'h0000000000, rng_ctl_ff} :
		hit_data ? rng_data : 64'h0000000000000000;

	// access sequencer
	always_comb begin
		case (state_ff)
			ST_IDLE: begin
				if (take) begin
					nxt_state = ST_ANSWER;
				end else if (reg_req_i && data_rd) begin
					nxt_state = ST_PACE;
				end else begin
					nxt_state = ST_IDLE;
				end
			end
			ST_PACE: nxt_state = take ? ST_ANSWER : ST_PACE;
			ST_ANSWER: nxt_state = ST_IDLE;
			default: nxt_state = ST_IDLE;
		endcase
	end

	// gap load: N+1 so the next take lands N+2 cycles on, or 64 in diagnostics
	assign nxt_pace = (take && data_rd) ?
		(lfsr_mode ? ({1'h0, wait_cnt} + 17'h00001) : (`DIAG_GAP_CYCLES - 17'h00001)) :
		(pace_busy ? (pace_ff - 17'h00001) : pace_ff);

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_ff <= ST_IDLE;
			pace_ff <= 17'h00000;
			data_ans_ff <= 1'h0;
			rdata_ff <= 64'h0000000000000000;
		end else begin
			state_ff <= nxt_state;
			pace_ff <= nxt_pace;
			data_ans_ff <= take && data_rd;
			if (take) begin
				// captured before the flush that this answer triggers
				rdata_ff <= reg_write_i ? 64'h0000000000000000 : rd_mux;
			end
		end
	end

	assign reg_ack_o = (state_ff == ST_ANSWER);
	assign reg_rdata_o = rdata_ff;

	// ------------------------------------------------------------------
	// generator control and per-cell oscillator rate
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rng_ctl_ff <= `RNG_CTL_RESET;
		end else if (wr_ctl) begin
			rng_ctl_ff <= reg_wdata_i[`RNG_CTL_WIDTH-1:0];
		end
	end

	// each cell keeps its last rate; software must walk the cells singly
	for (genvar c = 0; c < 3; c++) begin : g_rate
		always_ff @(posedge clk_i or negedge rst_b_i) begin
			if (!rst_b_i) begin
				rate_ff[c] <= 2'h0;
			end else if (wr_ctl && wr_cell_en[c]) begin
				rate_ff[c] <= reg_wdata_i[`RNG_RATE_LSB +: 2];
			end
		end
		assign osc_rate_o[2*c +: 2] = rate_ff[c];
	end

	assign cell_enable_o = cell_en;
	assign bias_bypass_o = rng_ctl_ff[`RNG_BYPASS_BIT];
	assign analog_mux_sel_o = rng_ctl_ff[`RNG_ANLG_LSB +: 2];

	// ------------------------------------------------------------------
	// clock generator control word
	// ------------------------------------------------------------------
	// the readable copy updates at once; the applied copy only under warm
	// reset, so clocks never change beneath running logic
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			clk_ctl_ff <= `CLK_CTL_RESET;
			applied_ff <= `CLK_CTL_RESET;
			serdes_ff <= 1'h0;
			mem_ps_ff <= `STRETCH_STEP_PS;
			core_ps_ff <= `STRETCH_STEP_PS;
		end else begin
			if (wr_clk) begin
				clk_ctl_ff <= reg_wdata_i[`CLK_CTL_WIDTH-1:0];
			end
			if (warm_reset_i) begin
				applied_ff <= clk_ctl_ff;
				mem_ps_ff <= stretch_ps(clk_ctl_ff[`CLK_MEM_STRETCH_LSB +: 2]);
				core_ps_ff <= stretch_ps(clk_ctl_ff[`CLK_CORE_STRETCH_LSB +: 2]);
			end
			serdes_ff <= warm_reset_i && (clk_ctl_ff[`CLK_DTM2_BIT] || clk_ctl_ff[`CLK_DTM1_BIT]);
		end
	end

	// applied field fan-out
	assign clamp_filter_o = applied_ff[`CLK_CLAMP_BIT];
	assign char_in_o = applied_ff[`CLK_CHAR_BIT];
	assign freq_change_o = applied_ff[`CLK_CHANGE_BIT];
	assign memory_stretch_delay_o = applied_ff[`CLK_MEM_STRETCH_LSB +: 2];
	assign core_stretch_delay_o = applied_ff[`CLK_CORE_STRETCH_LSB +: 2];
	assign memory_stretch_ps_o = mem_ps_ff;
	assign core_stretch_ps_o = core_ps_ff;
	// only memory domain sync pulses move; 11 behaves as no shift
	assign align_advance_o = (applied_ff[`CLK_ALIGN_LSB +: 2] == 2'h1);
	assign align_retard_o = (applied_ff[`CLK_ALIGN_LSB +: 2] == 2'h2);
	assign serial_test_mode_two_o = applied_ff[`CLK_DTM2_BIT];
	assign serial_test_mode_one_o = applied_ff[`CLK_DTM1_BIT];
	assign serdes_test_mode_o = serdes_ff;
	assign io_at_memory_rate_o = applied_ff[`CLK_DTM2_BIT] | applied_ff[`CLK_DTM1_BIT];
	assign stretch_phase_select_o = applied_ff[`CLK_PHASE_BIT];
	assign memory_vco_divider_o = applied_ff[`CLK_MEM_DIV_LSB +: 7];
	assign core_vco_divider_o = applied_ff[`CLK_CORE_DIV_LSB +: 6];
	assign feedback_divider_o = applied_ff[`CLK_FB_DIV_LSB +: 6];
	assign pre_scaler_o = applied_ff[`CLK_PRE_LSB +: 6];

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	// helper: distance between data read takes and the gap then required
	logic [16:0] since_ff;
	logic [16:0] need_ff;
	logic seen_ff, need_diag_ff;
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			since_ff <= 17'h00000;
			need_ff <= 17'h00000;
			seen_ff <= 1'h0;
			need_diag_ff <= 1'h0;
		end else if (take && data_rd) begin
			since_ff <= 17'h00001;
			need_ff <= lfsr_mode ? ({1'h0, wait_cnt} + 17'h00002) : `DIAG_GAP_CYCLES;
			seen_ff <= 1'h1;
			need_diag_ff <= !lfsr_mode;
		end else if (since_ff != 17'h1FFFF) begin
			since_ff <= since_ff + 17'h00001;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	a_zero_select: assert property (sel == 3'h0 |-> cell_en == 3'h0 && !feed_bit)
		else $error("empty select still enables a cell");
	a_single_select: assert property ((sel == 3'h1 || sel == 3'h2 || sel == 3'h4) |-> cell_en == sel)
		else $error("single select enables the wrong cell");
	a_multi_select: assert property ($countones(sel) >= 2 |-> cell_en == 3'h7)
		else $error("multiple select does not enable all cells");
	a_feed_xor: assert property (feed_bit == ^(noise_ff & cell_en))
		else $error("feed bit is not the xor of enabled cells");
	a_lfsr_step: assert property (rst_b_i && lfsr_mode && !data_ans_ff |=> rng_data == (({$past(rng_data[62:0]),
		$past(feed_bit)}) ^ ($past(rng_data[63]) ? `RNG_POLY : 64'h0000000000000000)))
		else $error("functional register step is wrong");
	a_flush_ones: assert property (data_ans_ff && lfsr_mode |=> rng_data == `RNG_ALL_ONES)
		else $error("no flush after functional data answer");
	a_pace_func: assert property (take && data_rd && seen_ff && !need_diag_ff |-> since_ff >= need_ff)
		else $error("functional data reads too close");
	a_plain_shift: assert property (!lfsr_mode && !$past(lfsr_mode) |-> rng_data[63:1] == $past(rng_data[62:0]))
		else $error("diagnostic register does not shift");
	a_pace_diag: assert property (take && data_rd && seen_ff && need_diag_ff |-> since_ff >= 17'd64)
		else $error("diagnostic data reads too close");
	a_diag_no_flush: assert property (data_ans_ff && !lfsr_mode |=> rng_data == {$past(rng_data[62:0]),
		$past(feed_bit)})
		else $error("diagnostic register was flushed");
	a_rate_apply: assert property (wr_ctl && wr_cell_en[0] |=> osc_rate_o[1:0] == $past(reg_wdata_i[7:6]))
		else $error("rate write missed the selected cell");
	a_rate_keep: assert property (wr_ctl && !wr_cell_en[2] |=> $stable(osc_rate_o[5:4]))
		else $error("rate write reached an unselected cell");
	a_applied_hold: assert property (!warm_reset_i |=> $stable(applied_ff))
		else $error("clock control applied without warm reset");
	a_serdes_reset: assert property (!warm_reset_i |=> !serdes_test_mode_o)
		else $error("serial test mode outside reset");
	a_read_value: assert property (take && data_rd |=> reg_ack_o && reg_rdata_o == $past(rng_data))
		else $error("data read did not return pre-flush value");

	c_func_read: cover property (take && data_rd && lfsr_mode ##1 reg_ack_o);
	c_diag_read: cover property (take && data_rd && !lfsr_mode);
	c_paced_wait: cover property (state_ff == ST_PACE ##[1:100] take);
	c_clk_apply: cover property (wr_clk ##[1:50] warm_reset_i);
endmodule : rng_with_clock_csr

// file: tb/reg_host_model.sv
/*
 * Register bus requester standing in for the processor cores.
 * Assumes: shares clk_i with the block; one access in flight at a time.
 */
`timescale 1ns/100ps

module reg_host_model (
	// clock
	input wire logic clk_i,
	// requester side of the register bus
	output logic reg_req_o,
	output logic reg_write_o,
	output logic [39:0] reg_addr_o,
	output logic [63:0] reg_wdata_o,
	input wire logic reg_ack_i,
	input wire logic [63:0] reg_rdata_i
);
	int cyc = 0;

	// idle bus at time zero
	initial begin
		reg_req_o = 1'h0;
		reg_write_o = 1'h0;
		reg_addr_o = 40'h0;
		reg_wdata_o = 64'h0;
	end

	// free running cycle count, used to time answers
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
	end

	// one access, held until the edge that samples the answer
	task automatic access(input logic wr, input logic [39:0] a, input logic [63:0] d,
		output logic [63:0] q, output int t, output logic ok);
		int n;
		n = 0;
		@(posedge clk_i);
		reg_req_o <= 1'h1;
		reg_write_o <= wr;
		reg_addr_o <= a;
		reg_wdata_o <= d;
		// answer taken at the edge that samples it, before that edge's updates land
		do begin
			@(posedge clk_i);
			n++;
		end while (reg_ack_i !== 1'h1 && n < 300);
		ok = reg_ack_i;
		q = reg_rdata_i;
		t = cyc;
		// released lines flip so a stale value never looks valid
		reg_req_o <= 1'h0;
		reg_write_o <= ~wr;
		reg_addr_o <= ~a;
		reg_wdata_o <= ~d;
	endtask : access
endmodule : reg_host_model

// file: tb/tb_top.sv
/*
 * Self-checking bench for the generator and clock register block.
 * Assumes: reg_host_model drives the register bus; noise cells driven here.
 */
`timescale 1ns/100ps
`include "rng_csr_consts.svh"

module tb_top;
	import rng_csr_pkg::*;
	typedef struct packed {
		logic [2:0] sel;
		logic [1:0] rate;
		logic [2:0] en;
		logic [5:0] osc;
	} row_t;
	// select, rate, expected enables and per-cell rates
	localparam row_t ROWS [8] = '{'{3'h1, 2'h0, 3'h1, 6'h00}, '{3'h2, 2'h2, 3'h2, 6'h08},
		'{3'h4, 2'h1, 3'h4, 6'h18}, '{3'h3, 2'h3, 3'h7, 6'h3F}, '{3'h0, 2'h0, 3'h0, 6'h3F},
		'{3'h5, 2'h0, 3'h7, 6'h00}, '{3'h6, 2'h1, 3'h7, 6'h15}, '{3'h7, 2'h2, 3'h7, 6'h2A}};
	localparam logic [53:0] CLK_DEF = {3'h1, 2'h0, 8'h28, 2'h0, 8'h28, 6'h00, 7'h08, 6'h01, 6'h07, 6'h01};
	localparam logic [53:0] CLK_NEW = {3'h6, 2'h2, 8'h78, 2'h3, 8'hA0, 6'h2B, 7'h55, 6'h2A, 6'h15, 6'h3F};
	localparam int TAP_LIST [30] = '{61, 57, 56, 52, 51, 50, 48, 47, 46, 43, 42, 41, 39, 38, 37, 35, 32,
		28, 25, 22, 21, 17, 15, 13, 12, 11, 7, 5, 1, 0};
	logic clk_i, rst_b_i, warm_reset_i, reg_req, reg_write, reg_ack;
	logic [2:0] noise_cell_i;
	logic [39:0] reg_addr;
	logic [63:0] reg_wdata, reg_rdata, taps, q, wd;
	cell_sel_t cell_en;
	logic [5:0] osc_rate, core_div, fb_div, pre;
	logic [1:0] anlg, mem_sd, core_sd;
	logic [7:0] mem_ps, core_ps;
	logic [6:0] mem_div;
	logic bypass, clamp, char_in, change, adv, ret, dtm2, dtm1, serdes, io_mem, phase;
	int err_count, n_compared, t0, t1, t2;
	wire logic [53:0] clk_outs = {clamp, char_in, change, mem_sd, mem_ps, core_sd, core_ps,
		adv, ret, dtm2, dtm1, io_mem, phase, mem_div, core_div, fb_div, pre};

	rng_with_clock_csr u_rng_with_clock_csr (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_req_i(reg_req), .reg_write_i(reg_write),
		.reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_ack_o(reg_ack), .reg_rdata_o(reg_rdata),
		.noise_cell_i(noise_cell_i), .cell_enable_o(cell_en), .osc_rate_o(osc_rate),
		.bias_bypass_o(bypass), .analog_mux_sel_o(anlg), .warm_reset_i(warm_reset_i),
		.clamp_filter_o(clamp), .char_in_o(char_in), .freq_change_o(change),
		.memory_stretch_delay_o(mem_sd), .memory_stretch_ps_o(mem_ps), .core_stretch_delay_o(core_sd),
		.core_stretch_ps_o(core_ps), .align_advance_o(adv), .align_retard_o(ret),
		.serial_test_mode_two_o(dtm2), .serial_test_mode_one_o(dtm1), .serdes_test_mode_o(serdes),
		.io_at_memory_rate_o(io_mem), .stretch_phase_select_o(phase), .memory_vco_divider_o(mem_div),
		.core_vco_divider_o(core_div), .feedback_divider_o(fb_div), .pre_scaler_o(pre));
	reg_host_model u_reg_host_model (.clk_i(clk_i), .reg_req_o(reg_req), .reg_write_o(reg_write),
		.reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_ack_i(reg_ack), .reg_rdata_i(reg_rdata));

	// ------------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------------
	task automatic check_word(input logic [63:0] got, input logic [63:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check_word

	task automatic check_gap(input int got, input int least);
		n_compared++;
		if (got < least) begin
			err_count++;
			$display("wrong value at %0t: read spacing %0d below %0d", $time, got, least);
		end
	endtask : check_gap

	// one access; settles past the release edge before anything is sampled
	task automatic bus(input logic wr, input logic [39:0] a, input logic [63:0] d, output int t);
		logic ok;
		u_reg_host_model.access(wr, a, d, q, t, ok);
		#1;
		check_word({63'h0, ok}, 64'h1, "answer");
	endtask : bus

	function automatic logic [63:0] step(input logic [63:0] v);
		return {v[62:0], 1'h0} ^ (v[63] ? taps : 64'h0);
	endfunction : step

	// true if v lies within the first 200 steps of the zero-fed walk from all ones
	function automatic logic on_walk(input logic [63:0] v);
		logic [63:0] w;
		w = 64'hFFFFFFFFFFFFFFFF;
		on_walk = 1'h0;
		for (int k = 0; k < 200; k++) begin
			on_walk = on_walk | (v === w);
			w = step(w);
		end
	endfunction : on_walk

	task automatic tally_and_finish;
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : tally_and_finish

	// ------------------------------------------------------------------
	// clock, watchdog and sequence
	// ------------------------------------------------------------------
	initial begin
		clk_i = 1'h0;
		forever #2.5 clk_i = ~clk_i;
	end

	// whole run is a few hundred cycles; this allows about twenty thousand
	initial begin
		#100000;
		err_count++;
		tally_and_finish();
	end

	initial begin
		rst_b_i = 1'h0;
		warm_reset_i = 1'h0;
		noise_cell_i = 3'h0;
		taps = 64'h0;
		foreach (TAP_LIST[i]) taps[TAP_LIST[i]] = 1'h1;
		repeat (5) @(posedge clk_i);
		rst_b_i <= 1'h1;
		@(posedge clk_i);
		#1;
		check_word({10'h0, clk_outs}, {10'h0, CLK_DEF}, "clock outputs");
		check_word({61'h0, cell_en}, 64'h7, "enables after reset");
		bus(1'h0, `CLK_CTL_ADDR, 64'h0, t0);
		check_word(q, 64'h00000001002011C1, "clock word reset");
		bus(1'h0, `RNG_CTL_ADDR, 64'h0, t0);
		check_word(q, 64'h7C0F, "control reset");
		// rate writes land only on the cells enabled by the same write
		foreach (ROWS[i]) begin
			wd = {39'h0, 16'h003E, ROWS[i].sel[0], ROWS[i].rate, ROWS[i].rate, 1'h1, ROWS[i].sel};
			bus(1'h1, `RNG_CTL_ADDR, wd, t0);
			bus(1'h0, `RNG_CTL_ADDR, 64'h0, t0);
			check_word(q, wd, "control readback");
			check_word({52'h0, cell_en, osc_rate, bypass, anlg},
				{52'h0, ROWS[i].en, ROWS[i].osc, ROWS[i].sel[0], ROWS[i].rate}, "cell outputs");
		end
		bus(1'h1, `CLK_CTL_ADDR, 64'h0000001A6F56A57F, t0);
		bus(1'h0, `CLK_CTL_ADDR, 64'h0, t0);
		check_word(q, 64'h0000001A6F56A57F, "clock readback");
		check_word({10'h0, clk_outs}, {10'h0, CLK_DEF}, "before warm reset");
		@(posedge clk_i);
		warm_reset_i <= 1'h1;
		repeat (2) @(posedge clk_i);
		warm_reset_i <= 1'h0;
		#1;
		check_word({63'h0, serdes}, 64'h1, "serial test");
		check_word({10'h0, clk_outs}, {10'h0, CLK_NEW}, "applied clock word");
		bus(1'h1, 40'h8300000008, 64'hFFFFFFFFFFFFFFFF, t0);
		bus(1'h0, 40'h8300000008, 64'h0, t0);
		check_word(q, 64'h0, "unmapped read");
		// diagnostic mode, all cells on, xor of 111 is one
		@(posedge clk_i);
		noise_cell_i <= 3'h7;
		bus(1'h1, `RNG_CTL_ADDR, 64'hA06, t0);
		repeat (80) @(posedge clk_i);
		bus(1'h0, `RNG_DATA_ADDR, 64'h0, t0);
		check_word(q, 64'hFFFFFFFFFFFFFFFF, "diag fill ones");
		// only cell 1 on, and it reads zero
		@(posedge clk_i);
		noise_cell_i <= 3'h5;
		bus(1'h1, `RNG_CTL_ADDR, 64'hA02, t1);
		repeat (80) @(posedge clk_i);
		bus(1'h0, `RNG_DATA_ADDR, 64'h0, t1);
		check_word(q, 64'h0, "diag fill zeros");
		// back to functional, no cells: a diag flush would show here
		bus(1'h1, `RNG_CTL_ADDR, 64'hA08, t2);
		bus(1'h0, `RNG_DATA_ADDR, 64'h0, t2);
		check_word(q, 64'h0, "no diag flush");
		check_gap(t2 - t1, 64);
		bus(1'h0, `RNG_DATA_ADDR, 64'h0, t1);
		check_gap(t1 - t2, 7);
		check_word({63'h0, on_walk(q)}, 64'h1, "flushed polynomial walk");
		// mid-run reset restores every default, the random register included
		@(posedge clk_i);
		rst_b_i <= 1'h0;
		repeat (2) @(posedge clk_i);
		rst_b_i <= 1'h1;
		@(posedge clk_i);
		#1;
		check_word({10'h0, clk_outs}, {10'h0, CLK_DEF}, "clock outputs after reset");
		check_word({52'h0, cell_en, osc_rate, bypass, anlg}, 64'h0000000000000E00, "cells after reset");
		check_word({63'h0, serdes}, 64'h0, "serial test after reset");
		bus(1'h0, `CLK_CTL_ADDR, 64'h0, t0);
		check_word(q, 64'h00000001002011C1, "clock word after reset");
		bus(1'h0, `RNG_DATA_ADDR, 64'h0, t0);
		check_word({63'h0, on_walk(q)}, 64'h1, "walk from reset state");
		tally_and_finish();
	end
endmodule : tb_top
